// *** core/aimc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module aimc_core
    import aimc_pkg::*;
#(
    parameter int SW = 16,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Serial input A
    input wire logic serial_data_in_a,
    input wire logic bit_clock_in_a,
    input wire logic word_select_in_a,
    // Serial input B
    input wire logic serial_data_in_b,
    input wire logic bit_clock_in_b,
    input wire logic word_select_in_b,
    // Address straps
    input wire logic addr_select_in_a,
    input wire logic addr_select_in_b,
    // Control
    input wire logic power_on_enable,
    input wire logic [1:0] operating_mode_sel,
    input wire logic input_sel,
    input wire logic [1:0] format_a,
    input wire logic [1:0] format_b,
    input wire logic [1:0] mono_sel_a,
    input wire logic [1:0] mono_sel_b,
    input wire logic [11:0] hp_coef,
    input wire logic [15:0] volume_gain,
    input wire logic compressor_en,
    input wire logic [15:0] compressor_gain,
    input wire logic [15:0] eq_gain,
    input wire logic [15:0] tone_gain,
    input wire logic [8:0] limit_level,
    // Status
    output logic [1:0] slave_addr,
    output aimc_mode_e mode_state,
    output logic [4:0] pcm_slots,
    output logic input_active,
    // Bridge outputs
    output logic bridge_out_pos,
    output logic bridge_out_neg,
    output logic pwm_enable
);
    typedef enum logic [2:0] {
        AIMC_ST_PDN, AIMC_ST_TON, AIMC_ST_RUN, AIMC_ST_MUTE, AIMC_ST_SWAP
    } aimc_state_e;

    function automatic logic signed [SW-1:0] gmul(
        input logic signed [SW-1:0] s, input logic [15:0] g);
        logic signed [SW+16:0] p;
        p = s * $signed({1'b0, g});
        return p[SW+13:14];
    endfunction

    // Three-stage synchronisers
    logic [2:0] sck_a, sck_b, ws_a, ws_b, sd_a, sd_b;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_a <= '0;
            sck_b <= '0;
            ws_a <= '0;
            ws_b <= '0;
            sd_a <= '0;
            sd_b <= '0;
        end else begin
            sck_a <= {sck_a[1:0], bit_clock_in_a};
            sck_b <= {sck_b[1:0], bit_clock_in_b};
            ws_a <= {ws_a[1:0], word_select_in_a};
            ws_b <= {ws_b[1:0], word_select_in_b};
            sd_a <= {sd_a[1:0], serial_data_in_a};
            sd_b <= {sd_b[1:0], serial_data_in_b};
        end
    end

    // Strap capture after reset release
    logic strap_done;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_done <= 1'b0;
            slave_addr <= AIMC_ADDR_BASE;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            slave_addr <= {addr_select_in_b, addr_select_in_a};
        end
    end

    // Input multiplexer: only the active port's sampled lines go on
    logic sel;
    logic sck_s, sck_p, ws_s, sd_s;
    logic [1:0] fmt, mono;
    assign sck_s = sel ? sck_b[2] : sck_a[2];
    assign sck_p = sel ? sck_b[1] : sck_a[1];
    assign ws_s = sel ? ws_b[2] : ws_a[2];
    assign sd_s = sel ? sd_b[2] : sd_a[2];
    assign fmt = sel ? format_b : format_a;
    assign mono = sel ? mono_sel_b : mono_sel_a;

    // Bit clock edge: stages two and three agree on the new level
    logic sck_q, ws_q;
    logic bit_tick, frame_tick;
    assign bit_tick = sck_p && sck_s && !sck_q;
    // Word select is compared bit to bit, not clock to clock
    assign frame_tick = bit_tick && (ws_s != ws_q);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck_s;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ws_q <= 1'b0;
        end else if (bit_tick) begin
            ws_q <= ws_s;
        end
    end

    // Receiver shift register
    logic [31:0] shreg;
    logic [5:0] bitcnt;
    logic signed [SW-1:0] left, right;
    logic word_done;
    logic [7:0] pcm_bits;
    logic [8:0] pcm_len;
    assign pcm_len = {1'b0, pcm_bits} + 9'h001;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= '0;
            bitcnt <= '0;
            left <= '0;
            right <= '0;
            word_done <= 1'b0;
            pcm_bits <= '0;
            pcm_slots <= '0;
        end else begin
            word_done <= 1'b0;
            if (bit_tick) begin
                shreg <= {shreg[30:0], sd_s};
                bitcnt <= frame_tick ? 6'h00 : bitcnt + 6'h01;
                if (fmt == AIMC_FMT_PCM) begin
                    // Frame runs sync to sync, counted in 8-bit slots
                    pcm_bits <= pcm_bits + 8'h01;
                    if (frame_tick && ws_s) begin
                        pcm_bits <= 8'h00;
                        pcm_slots <= 5'(pcm_len[8:3]);
                        left <= shreg[SW-1:0];
                        right <= shreg[SW-1:0];
                        word_done <= 1'b1;
                    end
                end else if (frame_tick) begin
                    // Left sits while word select is low
                    if (fmt == AIMC_FMT_I2S) begin
                        // The bit beside the word select change is the LSB
                        if (ws_s) left <= {shreg[SW-2:0], sd_s};
                        else right <= {shreg[SW-2:0], sd_s};
                    end else if (fmt == AIMC_FMT_MSBJ) begin
                        if (ws_s) left <= shreg[bitcnt -: SW];
                        else right <= shreg[bitcnt -: SW];
                    end else begin
                        if (ws_s) left <= shreg[SW-1:0];
                        else right <= shreg[SW-1:0];
                    end
                    word_done <= !ws_s;
                end
            end
        end
    end

    // Mono down-mix
    logic signed [SW-1:0] mono_sample;
    logic signed [SW:0] mix_sum;
    assign mix_sum = {left[SW-1], left} + {right[SW-1], right};
    always_comb begin
        case (mono)
            AIMC_MONO_L: mono_sample = left;
            AIMC_MONO_R: mono_sample = right;
            AIMC_MONO_SUM: mono_sample = mix_sum[SW:1];
            default: mono_sample = left;
        endcase
    end

    // Sample FIFO decouples receiver from the processing chain
    logic fifo_in_ready, fifo_valid, fifo_take;
    logic [SW-1:0] fifo_data;
    aimc_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_valid(word_done),
        .in_ready(fifo_in_ready),
        .in_data(mono_sample),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );
    fifo_room_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        word_done |-> fifo_in_ready)
        else $error("Sample arrived with the FIFO full");

    // Mode controller
    aimc_state_e st;
    logic [15:0] tcnt;
    logic [7:0] mute_cnt;
    logic [15:0] mute_gain;
    logic sel_req;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= AIMC_ST_PDN;
            tcnt <= '0;
            mute_cnt <= '0;
            sel <= 1'b0;
            mode_state <= AIMC_MODE_PDN;
        end else begin
            case (st)
                AIMC_ST_PDN: begin
                    mode_state <= AIMC_MODE_PDN;
                    if (power_on_enable &&
                        operating_mode_sel == 2'(AIMC_MODE_AMP)) begin
                        st <= AIMC_ST_TON;
                        tcnt <= '0;
                    end else if (power_on_enable &&
                        operating_mode_sel == 2'(AIMC_MODE_OFF)) begin
                        mode_state <= AIMC_MODE_OFF;
                    end
                end
                AIMC_ST_TON: begin
                    mode_state <= AIMC_MODE_AMP;
                    tcnt <= tcnt + 16'h0001;
                    if (tcnt == 16'(AIMC_TON_CYC - 1)) begin
                        st <= AIMC_ST_RUN;
                    end
                end
                AIMC_ST_RUN: begin
                    mode_state <= AIMC_MODE_AMP;
                    if (!power_on_enable ||
                        operating_mode_sel != 2'(AIMC_MODE_AMP)) begin
                        st <= AIMC_ST_MUTE;
                        mute_cnt <= '0;
                    end else if (sel_req != sel) begin
                        st <= AIMC_ST_SWAP;
                        mute_cnt <= '0;
                    end
                end
                AIMC_ST_MUTE: begin
                    if (mute_gain == 16'h0000) begin
                        st <= AIMC_ST_PDN;
                    end
                end
                AIMC_ST_SWAP: begin
                    if (fifo_take) begin
                        mute_cnt <= mute_cnt + 8'h01;
                    end
                    if (mute_cnt == 8'(AIMC_SW_MUTE_FS - 1) && fifo_take) begin
                        mode_state <= AIMC_MODE_OFF;
                        sel <= sel_req;
                        st <= AIMC_ST_TON;
                        tcnt <= '0;
                    end
                end
                default: st <= AIMC_ST_PDN;
            endcase
        end
    end
    assign sel_req = input_sel;
    assign input_active = sel;

    // Soft mute ramp, one step per sample
    logic ramp_up;
    assign ramp_up = (st == AIMC_ST_RUN);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mute_gain <= '0;
        end else if (st == AIMC_ST_PDN || st == AIMC_ST_TON) begin
            mute_gain <= '0;
        end else if (fifo_take) begin
            if (ramp_up && mute_gain < AIMC_UNITY) begin
                mute_gain <= mute_gain + 16'(AIMC_RAMP_STEP);
            end else if (!ramp_up && mute_gain != 16'h0000) begin
                mute_gain <= (mute_gain > 16'(AIMC_RAMP_STEP)) ?
                    mute_gain - 16'(AIMC_RAMP_STEP) : 16'h0000;
            end
        end
    end

    // Processing chain, one sample per PWM period
    logic [AIMC_PWM_BITS-1:0] pwm_cnt;
    assign fifo_take = fifo_valid && (pwm_cnt == '1);
    logic signed [SW-1:0] hp_y, hp_xd, s_vol, s_eq, s_tone, s_lim, s_out;
    logic signed [SW+12:0] hp_acc;
    logic signed [SW-1:0] lim_pos;
    assign hp_acc = (hp_y * $signed({1'b0, 13'h1000 - {1'b0, hp_coef}}));
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hp_y <= '0;
            hp_xd <= '0;
            s_out <= '0;
        end else if (fifo_take) begin
            hp_xd <= $signed(fifo_data);
            hp_y <= $signed(fifo_data) - hp_xd + hp_acc[SW+11:12];
            s_out <= gmul(s_lim, mute_gain);
        end
    end
    assign s_vol = gmul(hp_y, compressor_en ? compressor_gain
                                            : volume_gain);
    assign s_eq = gmul(s_vol, eq_gain);
    assign s_tone = gmul(s_eq, tone_gain);
    logic [8:0] lim_cl;
    assign lim_cl = (limit_level > AIMC_LIM_MAX) ? AIMC_LIM_MAX : limit_level;
    assign lim_pos = $signed({1'b0, {(SW-1){1'b1}}}) >>> lim_cl[8:4];
    assign s_lim = (s_tone > lim_pos) ? lim_pos :
                   (s_tone < -lim_pos) ? -lim_pos : s_tone;

    // Three-level PWM: one leg pulses per sign, both low for zero
    logic [AIMC_PWM_BITS-1:0] duty;
    logic [SW-1:0] s_mag;
    assign s_mag = s_out[SW-1] ? -s_out : s_out;
    assign duty = s_mag[SW-2 -: AIMC_PWM_BITS];
    assign pwm_enable = (st != AIMC_ST_PDN) && (mode_state == AIMC_MODE_AMP);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_cnt <= '0;
            bridge_out_pos <= 1'b0;
            bridge_out_neg <= 1'b0;
        end else begin
            pwm_cnt <= pwm_cnt + 1'b1;
            bridge_out_pos <= pwm_enable && !s_out[SW-1] &&
                (pwm_cnt < duty);
            bridge_out_neg <= pwm_enable && s_out[SW-1] &&
                (pwm_cnt < duty);
        end
    end

    pwm_off_pdn_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st == AIMC_ST_PDN |=> !bridge_out_pos && !bridge_out_neg)
        else $error("Bridge switching in power-down");
    never_both_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(bridge_out_pos && bridge_out_neg))
        else $error("Both bridge legs high");
    mode_needs_pwr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(st == AIMC_ST_TON) && $past(st) == AIMC_ST_PDN
        |-> $past(power_on_enable))
        else $error("Mode taken without power-up bit");
    sel_stable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $changed(sel) |-> $past(st) == AIMC_ST_SWAP)
        else $error("Input swapped outside the swap sequence");
    ton_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(st == AIMC_ST_TON) |-> (st == AIMC_ST_TON)[*8])
        else $error("Turn-on delay cut short");
    mute_ramp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st == AIMC_ST_MUTE && fifo_take && mute_gain != 0
        |=> mute_gain < $past(mute_gain))
        else $error("Mute ramp not falling");
    unmute_ramp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st == AIMC_ST_RUN && fifo_take && mute_gain < AIMC_UNITY
        |=> mute_gain > $past(mute_gain))
        else $error("Un-mute ramp not rising");
    limit_cap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_lim <= lim_pos && s_lim >= -lim_pos)
        else $error("Limiter exceeded");
    reset_pdn_a: assert property (@(posedge ref_clk)
        $rose(arst_n) |-> mode_state == AIMC_MODE_PDN)
        else $error("Not in power-down after reset");
endmodule
`default_nettype wire

// *** include/aimc_pkg.sv ***
// Overview of operation
// - Exactly one of two serial inputs is routed onward, chosen by host setting.
// - The receiver turns the chosen input into one internal mono sample stream.
// - A programmable high-pass stage removes DC before the volume stage.
// - Volume applies gain up to about +12 dB, set by host or compressor.
// - A single equalizer gain follows volume; a single tone gain follows equalizer.
// - Power limiter caps output, 0 dB down to about -90 dB in about 6 dB steps.
// - Modulator turns samples into a three-level PWM signal for the bridge.
// - Internal timing derives from ref_clk; bit clocks are only sampled by the receiver.
// - Three operating modes exist, selected by the host.
// - Power-down keeps PWM outputs disabled with control still working.
// - Off mode keeps the amplifier off and PWM disabled, bias active.
// - Amplifier mode drives the differential output from the selected input.
// - After amplifier mode is chosen and turn-on delay passes, soft un-mute ramps.
// - Writing mode zero causes a soft mute ramp, not an abrupt cut.
// - Receiver accepts I2S-family and PCM framings; format field picks variant.
// - For PCM the slot count is measured from bit clocks per frame sync.
// - Two address-select inputs choose the control slave address.
// - Input toggle: mute 128/fs, go off, swap input, return, unmute.
// - Per-interface channel select: left, right, or half their sum.
package aimc_pkg;
    typedef enum logic [1:0] {
        AIMC_MODE_PDN, AIMC_MODE_OFF, AIMC_MODE_AMP, AIMC_MODE_RSV
    } aimc_mode_e;
    localparam logic [1:0] AIMC_FMT_I2S = 2'h0;
    localparam logic [1:0] AIMC_FMT_MSBJ = 2'h1;
    localparam logic [1:0] AIMC_FMT_LSBJ = 2'h2;
    localparam logic [1:0] AIMC_FMT_PCM = 2'h3;
    localparam logic [1:0] AIMC_MONO_L = 2'h0;
    localparam logic [1:0] AIMC_MONO_R = 2'h1;
    localparam logic [1:0] AIMC_MONO_SUM = 2'h2;
    localparam int AIMC_SW_MUTE_FS = 128;
    localparam int AIMC_RAMP_STEP = 16'h0100;
    localparam logic [15:0] AIMC_UNITY = 16'h4000;
    localparam logic [8:0] AIMC_LIM_MAX = 9'h0F8;
    localparam int AIMC_TON_NS = 1000;
    localparam int AIMC_CLK_NS = 20;
    localparam int AIMC_TON_CYC = (AIMC_TON_NS + AIMC_CLK_NS - 1) / AIMC_CLK_NS;
    localparam int AIMC_PWM_BITS = 8;
    localparam logic [1:0] AIMC_ADDR_BASE = 2'h0;
endpackage

// *** core/aimc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module aimc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;

    assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
        (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
        end else if (in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ptr <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    fifo_no_overflow_a: assert property (@(posedge ref_clk) disable iff
        (!arst_n) full |-> ##1 (wr_ptr == $past(wr_ptr)) || !full)
        else $error("FIFO pointer moved while full");
endmodule
`default_nettype wire

// *** tb/aimc_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aimc_src_model #(
    parameter realtime HALF_NS = 80.0,
    parameter realtime PHASE_NS = 3.0
) (
    // Control
    input wire logic run,
    input wire logic [15:0] level,
    // Serial link
    output logic sck,
    output logic ws,
    output logic sd
);
    logic [31:0] frame;
    logic [3:0] n;
    initial begin
        sck = 1'b0;
        ws = 1'b0;
        sd = 1'b0;
        n = 4'h0;
        #(PHASE_NS);
        forever begin
            if (!run) begin
                // Clock stands still; idle data never holds a stale bit
                sd = ~sd;
                #(2.0 * HALF_NS);
            end else begin
                n = n + 4'h1;
                // Same square wave at fs/16 on both channels
                frame = n[3] ? {~level, ~level} : {level, level};
                for (int i = 0; i < 32; i++) begin
                    ws = (i >= 15) && (i != 31);
                    sd = frame[31 - i];
                    #(HALF_NS);
                    sck = 1'b1;
                    #(HALF_NS);
                    sck = 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import aimc_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic run_a = 1'b1;
    logic run_b = 1'b1;
    logic sd_a, sck_a, ws_a, sd_b, sck_b, ws_b;
    logic pwr = 1'b0;
    logic isel = 1'b0;
    logic cmp_en = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] fmt_a = AIMC_FMT_I2S;
    logic [1:0] fmt_b = AIMC_FMT_I2S;
    logic [1:0] mono_a = AIMC_MONO_L;
    logic [1:0] mono_b = AIMC_MONO_L;
    logic [11:0] hp = 12'h001;
    logic [15:0] vol = AIMC_UNITY;
    logic [15:0] eq = AIMC_UNITY;
    logic [8:0] lim = 9'h000;
    logic [1:0] slave_addr;
    aimc_mode_e mode_state;
    logic [4:0] pcm_slots;
    logic input_active, bout_p, bout_n, pwm_en;
    logic [3:0] act;
    int n;
    int cyc = 0;
    int miscompares = 0;
    int num_checks = 0;

    always #10 ref_clk = ~ref_clk;

    aimc_src_model #(.PHASE_NS(3.0)) u_src_a (.run(run_a),
        .level(16'h3000), .sck(sck_a), .ws(ws_a), .sd(sd_a));
    aimc_src_model #(.PHASE_NS(47.0)) u_src_b (.run(run_b),
        .level(16'h2000), .sck(sck_b), .ws(ws_b), .sd(sd_b));

    aimc_core u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .serial_data_in_a(sd_a), .bit_clock_in_a(sck_a),
        .word_select_in_a(ws_a), .serial_data_in_b(sd_b),
        .bit_clock_in_b(sck_b), .word_select_in_b(ws_b),
        .addr_select_in_a(1'b1), .addr_select_in_b(1'b0),
        .power_on_enable(pwr), .operating_mode_sel(mode),
        .input_sel(isel), .format_a(fmt_a), .format_b(fmt_b),
        .mono_sel_a(mono_a), .mono_sel_b(mono_b), .hp_coef(hp),
        .volume_gain(vol), .compressor_en(cmp_en),
        .compressor_gain(AIMC_UNITY), .eq_gain(eq),
        .tone_gain(AIMC_UNITY), .limit_level(lim),
        .slave_addr(slave_addr), .mode_state(mode_state),
        .pcm_slots(pcm_slots), .input_active(input_active),
        .bridge_out_pos(bout_p), .bridge_out_neg(bout_n),
        .pwm_enable(pwm_en));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [3:0] exp,
                           input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input string what, input aimc_mode_e exp);
        num_checks++;
        if (mode_state !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp,
                     mode_state);
        end
    endtask

    // Reports 1 if either bridge output went high within the window
    task automatic watch(input int cycles, output logic [3:0] hit);
        hit = 4'h0;
        repeat (cycles) begin
            @(posedge ref_clk);
            #1;
            if (bout_p === 1'b1 || bout_n === 1'b1) begin
                hit = 4'h1;
            end
        end
    endtask

    task automatic wait_mode(input string what, input aimc_mode_e exp,
                             input int limit, output int cnt);
        cnt = 0;
        while (mode_state !== exp && cnt < limit) begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
        chk_mode(what, exp);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 95000) begin
            miscompares++;
            $display("[FAIL] cycle_limit expected 0 seen 1");
            stop_test();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_val("slave_addr", 4'h1, {2'b00, slave_addr});
        chk_mode("mode_after_reset", AIMC_MODE_PDN);
        chk_val("pwm_en_reset", 4'h0, {3'b000, pwm_en});
        mode = 2'h2;
        watch(300, act);
        chk_mode("mode_no_power_bit", AIMC_MODE_PDN);
        chk_val("pdn_bridge", 4'h0, act);
        pwr = 1'b1;
        mode = 2'h1;
        wait_mode("mode_off", AIMC_MODE_OFF, 200, n);
        watch(300, act);
        chk_val("off_bridge", 4'h0, act);
        chk_val("off_pwm_en", 4'h0, {3'b000, pwm_en});
        mode = 2'h2;
        wait_mode("mode_amp", AIMC_MODE_AMP, 400, n);
        for (int k = 0; k < 3; k++) begin
            fmt_a = k[1:0];
            mono_a = k[1:0];
            cmp_en = k[0];
            vol = AIMC_UNITY + 16'(k * 16'h1000);
            lim = 9'(k * 2);
            hp = 12'(k + 1);
            watch(2048, act);
            chk_val("amp_bridge", 4'h1, act);
        end
        chk_val("amp_pwm_en", 4'h1, {3'b000, pwm_en});
        chk_val("sel_a", 4'h0, {3'b000, input_active});
        fmt_a = AIMC_FMT_I2S;
        mono_b = AIMC_MONO_SUM;
        isel = 1'b1;
        wait_mode("swap_off", AIMC_MODE_OFF, 40000, n);
        chk_val("swap_mute", 4'h1, {3'b000, n >= 32512});
        run_a = 1'b0;
        wait_mode("swap_back", AIMC_MODE_AMP, 2000, n);
        chk_val("sel_b", 4'h1, {3'b000, input_active});
        watch(4096, act);
        chk_val("b_bridge", 4'h1, act);
        eq = 16'h0000;
        repeat (300) @(posedge ref_clk);
        #1;
        watch(1024, act);
        chk_val("eq_zero", 4'h0, act);
        eq = AIMC_UNITY;
        lim = 9'h0F8;
        repeat (300) @(posedge ref_clk);
        #1;
        watch(1024, act);
        chk_val("lim_floor", 4'h0, act);
        lim = 9'h000;
        fmt_b = AIMC_FMT_PCM;
        watch(1024, act);
        // 32 bit clocks per frame sync make four 8-bit slots
        chk_val("pcm_slots", 4'h4, pcm_slots[3:0]);
        chk_val("pcm_slots_hi", 4'h0, {3'b000, pcm_slots[4]});
        mode = 2'h0;
        repeat (20) @(posedge ref_clk);
        #1;
        chk_val("mute_soft", 4'h1, {3'b000, pwm_en});
        wait_mode("mute_pdn", AIMC_MODE_PDN, 20000, n);
        chk_val("pdn_pwm_en", 4'h0, {3'b000, pwm_en});
        mode = 2'h3;
        watch(300, act);
        chk_val("mode_rsv", 4'h0,
                {3'b000, mode_state == AIMC_MODE_AMP});
        stop_test();
    end
endmodule
`default_nettype wire
